/* swc_top.sv */
`timescale 1ns/1ps
module swc_top
  import swc_pkg::*;
#(
  parameter int POR_CYC = SWC_POR_DELAY_CYC,
  parameter int RC_HZ = 32000
) (
  input wire logic clk_i,                // System clock.
  input wire logic rst_i,                // Power-on reset, high.
  input wire logic [11:0] s_axi_awaddr,  // Write address.
  input wire logic s_axi_awvalid,        // Write address valid.
  output logic s_axi_awready,            // Write address ready.
  input wire logic [31:0] s_axi_wdata,   // Write data.
  input wire logic [3:0] s_axi_wstrb,    // Write strobes.
  input wire logic s_axi_wvalid,         // Write data valid.
  output logic s_axi_wready,             // Write data ready.
  output logic [1:0] s_axi_bresp,        // Write response.
  output logic s_axi_bvalid,             // Write response valid.
  input wire logic s_axi_bready,         // Write response ready.
  input wire logic [11:0] s_axi_araddr,  // Read address.
  input wire logic s_axi_arvalid,        // Read address valid.
  output logic s_axi_arready,            // Read address ready.
  output logic [31:0] s_axi_rdata,       // Read data.
  output logic [1:0] s_axi_rresp,        // Read response.
  output logic s_axi_rvalid,             // Read data valid.
  input wire logic s_axi_rready,         // Read data ready.
  input wire logic [7:0] port0_i,        // Port 0 pin levels.
  input wire logic [7:0] port2_i,        // Port 2 pin levels.
  input wire logic [7:0] port3_i,        // Port 3 pin levels.
  input wire logic [7:0] port0_out_i,    // Port 0 bits set as outputs.
  input wire logic [7:0] port2_out_i,    // Port 2 bits set as outputs.
  input wire logic [7:0] port3_out_i,    // Port 3 bits set as outputs.
  input wire logic stop_req_i,           // Processor enters stop, pulse.
  input wire logic halt_i,               // Processor is halted, level.
  input wire logic wdt_kick_i,           // Watchdog instruction, pulse.
  input wire logic rc_tick_i,            // RC oscillator tick, pulse.
  input wire logic wdt_otp_i,            // Watchdog runs from power-on.
  input wire logic brownout_i,           // Supply below brownout level.
  input wire logic supply_low_i,         // Supply below low threshold.
  input wire logic supply_high_i,        // Supply above high threshold.
  input wire logic interrupt_request_five_clr_i,           // Clear request five, pulse.
  output logic cpu_reset_o,              // Processor held in reset.
  output logic cpu_run_o,                // Processor may execute.
  output logic [15:0] restart_addr_o,    // Restart address.
  output logic interrupt_request_five_o                    // Interrupt request five.
);

  // ---------------------------------------------------------------------------
  // Derived counts
  // ---------------------------------------------------------------------------
  localparam int WD0 = (SWC_WD_MS0 * RC_HZ + 999) / 1000;
  localparam int WD1 = (SWC_WD_MS1 * RC_HZ + 999) / 1000;
  localparam int WD2 = (SWC_WD_MS2 * RC_HZ + 999) / 1000;
  localparam int WD3 = (SWC_WD_MS3 * RC_HZ + 999) / 1000;
  localparam int PW = $clog2(POR_CYC + 1);
  localparam int WW = $clog2(WD3 + 1);

  swc_state_t state_reg, state_next;
  logic [PW-1:0] por_cnt_reg;
  logic [6:0] win_cnt_reg;
  logic [WW-1:0] wd_cnt_reg;
  logic wd_en_reg;
  logic [2:0] src1_reg, src2_reg;
  logic dly_reg, lvl1_reg, lvl2_reg, warm_reg;
  logic [1:0] tsel_reg;
  logic wd_halt_reg, wd_stop_reg, lvd_en_reg, interrupt_request_five_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_full_reg, w_full_reg;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // Address and data are latched separately; the write fires when both held.
  wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire [9:0] widx = awaddr_reg[11:2];
  wire [9:0] ridx = s_axi_araddr[11:2];
  wire lane0 = wstrb_reg[0];
  wire wr_smr = do_write && lane0 && (widx == SWC_IDX_SMR);
  wire wr_stop_wake_config_second = do_write && lane0 && (widx == SWC_IDX_STOP_WAKE_CONFIG_SECOND);
  wire wr_lvd = do_write && lane0 && (widx == SWC_IDX_LVD);
  wire in_window = (state_reg == SWC_ST_RUN) &&
                   (win_cnt_reg < 7'(SWC_WR_WINDOW_CYC));
  wire wr_watchdog_mode_config = do_write && lane0 && (widx == SWC_IDX_WATCHDOG_MODE_CONFIG) &&
                  in_window;
  wire w_mapped = (widx == SWC_IDX_SMR) || (widx == SWC_IDX_STOP_WAKE_CONFIG_SECOND) ||
                  (widx == SWC_IDX_LVD) || (widx == SWC_IDX_WATCHDOG_MODE_CONFIG);
  wire r_mapped = (ridx == SWC_IDX_SMR) || (ridx == SWC_IDX_STOP_WAKE_CONFIG_SECOND) ||
                  (ridx == SWC_IDX_LVD) || (ridx == SWC_IDX_WATCHDOG_MODE_CONFIG);
  wire rd_take = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_arready = !s_axi_rvalid;

  // ---------------------------------------------------------------------------
  // Wake equations
  // ---------------------------------------------------------------------------
  // Output pins are forced to the neutral level of the gate they feed.
  wire [7:0] p2_nor = port2_i & ~port2_out_i;
  wire [7:0] p2_nand = port2_i | port2_out_i;
  wire [2:0] p3_nor = port3_i[3:1] & ~port3_out_i[3:1];
  wire [2:0] p3_nand = port3_i[3:1] | port3_out_i[3:1];
  wire [1:0] p0_nor = {port0_i[7], port0_i[0]} &
                      ~{port0_out_i[7], port0_out_i[0]};
  wire [1:0] p0_nand = {port0_i[7], port0_i[0]} |
                       {port0_out_i[7], port0_out_i[0]};
  logic src1_val, src1_on, src2_val, src2_on;

  // First register source; a single pin counts only while it is an input.
  always_comb begin
    src1_on = 1'b1;
    unique case (src1_reg)
      3'h2: src1_val = p3_nor[0];
      3'h3: src1_val = p3_nor[1];
      3'h4: src1_val = p3_nor[2];
      3'h5: src1_val = p2_nor[7];
      3'h6: src1_val = ~|p2_nor[3:0];
      3'h7: src1_val = ~|p2_nor;
      default: begin
        src1_val = 1'b0;
        src1_on = 1'b0;
      end
    endcase
    if ((src1_reg >= 3'h2) && (src1_reg <= 3'h4)) begin
      src1_on = !port3_out_i[src1_reg - 3'h1];
    end else if (src1_reg == 3'h5) begin
      src1_on = !port2_out_i[7];
    end
  end

  // Second register source.
  always_comb begin
    src2_on = (src2_reg != 3'h0);
    unique case (src2_reg)
      3'h1: src2_val = ~&p2_nand[3:0];
      3'h2: src2_val = ~&p2_nand;
      3'h3: src2_val = ~|p3_nor;
      3'h4: src2_val = ~&p3_nand;
      3'h5: src2_val = ~|{p3_nor, p0_nor};
      3'h6: src2_val = ~&{p3_nand, p0_nand};
      3'h7: src2_val = ~&{p3_nand, p2_nand[2:0]};
      default: src2_val = 1'b0;
    endcase
  end

  wire wake1 = src1_on && (src1_val == lvl1_reg);
  wire wake2 = src2_on && (src2_val == lvl2_reg);
  wire wake_any = wake1 || wake2;
  wire stop_wake = (state_reg == SWC_ST_STOP) && wake_any;

  // ---------------------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------------------
  logic [WW-1:0] wd_limit;
  always_comb begin
    unique case (tsel_reg)
      2'h0: wd_limit = WW'(WD0);
      2'h1: wd_limit = WW'(WD1);
      2'h2: wd_limit = WW'(WD2);
      default: wd_limit = WW'(WD3);
    endcase
  end

  wire wd_paused = (halt_i && !wd_halt_reg) ||
                   ((state_reg == SWC_ST_STOP) && !wd_stop_reg);
  wire wd_count = wd_en_reg && rc_tick_i && !wd_paused &&
                  (state_reg != SWC_ST_POR);
  wire wd_expire = wd_count && (wd_cnt_reg >= wd_limit - WW'(1));

  // Enabled once by the instruction or the option; each kick restarts it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_en_reg <= 1'b0;
      wd_cnt_reg <= '0;
    end else begin
      if (state_reg == SWC_ST_POR && por_cnt_reg == '0) begin
        wd_en_reg <= wdt_otp_i;
      end else if (wdt_kick_i) begin
        wd_en_reg <= 1'b1;
      end
      if (wdt_kick_i || wd_expire || state_reg == SWC_ST_POR) begin
        wd_cnt_reg <= '0;
      end else if (wd_count) begin
        wd_cnt_reg <= wd_cnt_reg + WW'(1);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SWC_ST_POR: if (!brownout_i && por_cnt_reg == PW'(POR_CYC)) begin
        state_next = SWC_ST_RUN;
      end
      SWC_ST_RUN: if (stop_req_i) begin
        state_next = SWC_ST_STOP;
      end
      SWC_ST_STOP: if (stop_wake) begin
        state_next = dly_reg ? SWC_ST_POR : SWC_ST_RUN;
      end
    endcase
    if (brownout_i || wd_expire) begin
      state_next = SWC_ST_POR;
    end
  end

  // State, power-on delay and write window counters.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SWC_ST_POR;
      por_cnt_reg <= '0;
      win_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (brownout_i || state_next != SWC_ST_POR ||
          state_reg != SWC_ST_POR) begin
        por_cnt_reg <= '0;
      end else begin
        por_cnt_reg <= por_cnt_reg + PW'(1);
      end
      if (state_reg != SWC_ST_RUN) begin
        win_cnt_reg <= '0;
      end else if (win_cnt_reg < 7'(SWC_WR_WINDOW_CYC)) begin
        win_cnt_reg <= win_cnt_reg + 7'h01;
      end
    end
  end

  assign cpu_reset_o = (state_reg == SWC_ST_POR);
  assign cpu_run_o = (state_reg == SWC_ST_RUN);

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // Only defined fields are stored, so reserved bits never act.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src1_reg <= SWC_SRC_RST;
      dly_reg <= SWC_DLY_RST;
      lvl1_reg <= SWC_LVL_RST;
      src2_reg <= SWC_SRC_RST;
      lvl2_reg <= SWC_LVL_RST;
      tsel_reg <= SWC_WD_TSEL_RST;
      wd_halt_reg <= SWC_WD_HALT_RST;
      wd_stop_reg <= SWC_WD_STOP_RST;
      lvd_en_reg <= SWC_LVD_EN_RST;
      warm_reg <= 1'b0;
      restart_addr_o <= SWC_RESTART_ADDR;
    end else begin
      if (wr_smr) begin
        src1_reg <= wdata_reg[SWC_SRC_MSB:SWC_SRC_LSB];
        dly_reg <= wdata_reg[SWC_DLY_BIT];
        lvl1_reg <= wdata_reg[SWC_LVL_BIT];
      end
      if (wr_stop_wake_config_second) begin
        src2_reg <= wdata_reg[SWC_SRC_MSB:SWC_SRC_LSB];
        lvl2_reg <= wdata_reg[SWC_LVL_BIT];
      end
      if (wr_watchdog_mode_config) begin
        tsel_reg <= wdata_reg[SWC_WD_TSEL_MSB:SWC_WD_TSEL_LSB];
        wd_halt_reg <= wdata_reg[SWC_WD_HALT_BIT];
        wd_stop_reg <= wdata_reg[SWC_WD_STOP_BIT];
      end
      if (wr_lvd) begin
        lvd_en_reg <= wdata_reg[SWC_LVD_EN_BIT];
      end
      if (stop_wake) begin
        warm_reg <= 1'b1;
      end else if (brownout_i || wd_expire) begin
        warm_reg <= 1'b0;
      end
      restart_addr_o <= SWC_RESTART_ADDR;
    end
  end

  // ---------------------------------------------------------------------------
  // Voltage detection
  // ---------------------------------------------------------------------------
  wire vd_live = lvd_en_reg && (state_reg != SWC_ST_STOP);
  wire low_flag = vd_live && supply_low_i;
  wire high_flag = vd_live && supply_high_i;

  // The request is sticky; a new low reading wins over a clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_request_five_reg <= 1'b0;
    end else if (low_flag) begin
      interrupt_request_five_reg <= 1'b1;
    end else if (interrupt_request_five_clr_i) begin
      interrupt_request_five_reg <= 1'b0;
    end
  end
  assign interrupt_request_five_o = interrupt_request_five_reg;

  // ---------------------------------------------------------------------------
  // Bus channels
  // ---------------------------------------------------------------------------
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (ridx == SWC_IDX_SMR) begin
      rdata_next[SWC_FLAG_BIT] = warm_reg;
    end else if (ridx == SWC_IDX_LVD) begin
      rdata_next[SWC_LVD_EN_BIT] = lvd_en_reg;
      rdata_next[SWC_LVD_LOW_BIT] = low_flag;
      rdata_next[SWC_LVD_HIGH_BIT] = high_flag;
    end
    // The watchdog mode and second wake registers read as zero.
  end

  // Write address and data holding, and the write answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SWC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_mapped ? SWC_RESP_OKAY : SWC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read answer, one cycle after the address is taken.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SWC_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= r_mapped ? SWC_RESP_OKAY : SWC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  watchdog_mode_config_window_a: assert property (
    (state_reg == SWC_ST_RUN && win_cnt_reg >= 7'(SWC_WR_WINDOW_CYC))
    |=> $stable(tsel_reg) && $stable(wd_halt_reg) && $stable(wd_stop_reg))
    else $error("Watchdog mode changed after the write window.");
  wake_delay_a: assert property (
    (stop_wake && dly_reg && !brownout_i && !wd_expire)
    |=> state_reg == SWC_ST_POR)
    else $error("Wake with delay did not enter the power-on delay.");
  wake_fast_a: assert property (
    (state_reg == SWC_ST_STOP && wake_any && !dly_reg && !brownout_i &&
     !wd_expire) |=> cpu_run_o)
    else $error("Fast wake did not resume execution.");
  warm_flag_a: assert property (
    stop_wake |=> warm_reg ##0 (rdata_next[SWC_FLAG_BIT] ||
                                ridx != SWC_IDX_SMR))
    else $error("Warm start flag not set by stop wake.");
  brownout_hold_a: assert property (
    brownout_i |=> cpu_reset_o && por_cnt_reg == '0)
    else $error("Brownout did not hold reset.");
  vd_stop_a: assert property (
    (state_reg == SWC_ST_STOP) |-> !low_flag && !high_flag)
    else $error("Voltage flags live during stop.");
  interrupt_request_five_sticky_a: assert property (
    (interrupt_request_five_reg && !interrupt_request_five_clr_i) |=> interrupt_request_five_reg)
    else $error("Request five dropped without a clear.");
  wd_reset_a: assert property (
    wd_expire |=> cpu_reset_o ##1 cpu_reset_o)
    else $error("Watchdog expiry did not reset the processor.");
  wd_pause_a: assert property (
    (halt_i && !wd_halt_reg && !wdt_kick_i && state_reg == SWC_ST_RUN)
    |=> $stable(wd_cnt_reg))
    else $error("Watchdog counted during halt while paused.");
  nor_mask_a: assert property (
    (src1_reg == 3'h7 && (port2_out_i == 8'hFF)) |-> src1_val)
    else $error("Output pins were not excluded from the wake gate.");

  cover_wake_c: cover property (stop_wake);
  cover_wd_c: cover property (wd_expire);
  cover_interrupt_request_five_c: cover property (low_flag && !interrupt_request_five_reg);
  cover_wr_c: cover property (wr_watchdog_mode_config);

endmodule

/* swc_pkg.sv */
// ---------------------------------------------------------------------------
// Shared constants of the stop-wake and watchdog controller.
// ---------------------------------------------------------------------------
package swc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] SWC_IDX_SMR = 10'h00B;
  localparam logic [9:0] SWC_IDX_LVD = 10'h00C;
  localparam logic [9:0] SWC_IDX_STOP_WAKE_CONFIG_SECOND = 10'h00D;
  localparam logic [9:0] SWC_IDX_WATCHDOG_MODE_CONFIG = 10'h00F;

  // Field positions of the stop-wake registers.
  localparam int SWC_SRC_LSB = 2;
  localparam int SWC_SRC_MSB = 4;
  localparam int SWC_DLY_BIT = 5;
  localparam int SWC_LVL_BIT = 6;
  localparam int SWC_FLAG_BIT = 7;

  // Field positions of the watchdog mode and voltage registers.
  localparam int SWC_WD_TSEL_LSB = 0;
  localparam int SWC_WD_TSEL_MSB = 1;
  localparam int SWC_WD_HALT_BIT = 2;
  localparam int SWC_WD_STOP_BIT = 3;
  localparam int SWC_LVD_EN_BIT = 0;
  localparam int SWC_LVD_LOW_BIT = 1;
  localparam int SWC_LVD_HIGH_BIT = 2;

  // Reset values.
  localparam logic [2:0] SWC_SRC_RST = 3'h0;
  localparam logic SWC_DLY_RST = 1'b1;
  localparam logic SWC_LVL_RST = 1'b0;
  localparam logic [1:0] SWC_WD_TSEL_RST = 2'h0;
  localparam logic SWC_WD_HALT_RST = 1'b1;
  localparam logic SWC_WD_STOP_RST = 1'b1;
  localparam logic SWC_LVD_EN_RST = 1'b0;

  // Timing: clock rate, power-on delay, write window and watchdog taps.
  localparam int SWC_CLK_HZ = 25_000_000;
  localparam int SWC_POR_DELAY_US = 2500;
  localparam int SWC_POR_DELAY_CYC =
    (SWC_POR_DELAY_US * (SWC_CLK_HZ / 1_000_000));
  localparam int SWC_WR_WINDOW_CYC = 60;
  localparam int SWC_WAKE_HOLD_CYC = 10;
  localparam int SWC_WD_MS0 = 5;
  localparam int SWC_WD_MS1 = 10;
  localparam int SWC_WD_MS2 = 20;
  localparam int SWC_WD_MS3 = 80;
  localparam logic [15:0] SWC_RESTART_ADDR = 16'h000C;

  // Bus answers.
  localparam logic [1:0] SWC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SWC_RESP_SLVERR = 2'h2;

  // Sequencer states.
  typedef enum logic [1:0] {
    SWC_ST_POR,
    SWC_ST_RUN,
    SWC_ST_STOP
  } swc_state_t;

endpackage

/* swc_pins.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Port pins that act as wake sources: idle high, short low burst on port 2 bits 7 to 1 on request.
// ---------------------------------------------------------------------------
module swc_pins #(
  parameter int HOLD = 12
) (
  input wire logic clk_i,      // System clock.
  input wire logic wake_i,     // Start a wake burst, pulse.
  output logic [7:0] port0_o,  // Port 0 levels.
  output logic [7:0] port2_o,  // Port 2 levels.
  output logic [7:0] port3_o   // Port 3 levels.
);
  int cnt = 0;
  // The burst lasts HOLD cycles so a fast wake still sees it.
  always_ff @(posedge clk_i) begin
    if (wake_i) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Bit 0 of port 2 stays high in a burst, as a pin that drives out would.
  assign port2_o = (cnt > 0) ? 8'h01 : 8'hFF;
  assign port0_o = 8'hFF;
  assign port3_o = 8'hFF;
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Register, wake, watchdog and supply tests of the controller.
// ---------------------------------------------------------------------------
module tb_top;
  import swc_pkg::*;
  localparam logic [11:0] a_wake1 = {SWC_IDX_SMR, 2'b00};
  localparam logic [11:0] a_volt = {SWC_IDX_LVD, 2'b00};
  localparam logic [11:0] a_wake2 = {SWC_IDX_STOP_WAKE_CONFIG_SECOND, 2'b00};
  localparam logic [11:0] a_wdog = {SWC_IDX_WATCHDOG_MODE_CONFIG, 2'b00};
  logic clk_i = 0, rst_i = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_reset_o, cpu_run_o, interrupt_request_five_o, wake = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] port0_i, port2_i, port3_i, port2_out_i = 0;
  logic stop_req_i = 0, halt_i = 0, wdt_kick_i = 0, rc_tick_i = 0;
  logic brownout_i = 0, supply_low_i = 0, supply_high_i = 0, interrupt_request_five_clr_i = 0;
  logic [15:0] restart_addr_o;
  logic wdt_otp = 0;
  int errors = 0, num_checks = 0, cyc = 0;
  swc_top #(.POR_CYC(20), .RC_HZ(1000)) swc_top_i (.clk_i, .rst_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port0_i, .port2_i, .port3_i, .port0_out_i(8'h00), .port2_out_i,
    .port3_out_i(8'h00), .stop_req_i, .halt_i, .wdt_kick_i, .rc_tick_i,
    .wdt_otp_i(wdt_otp), .brownout_i, .supply_low_i, .supply_high_i,
    .interrupt_request_five_clr_i, .cpu_reset_o, .cpu_run_o, .restart_addr_o, .interrupt_request_five_o);
  swc_pins swc_pins_i (.clk_i, .wake_i(wake), .port0_o(port0_i),
    .port2_o(port2_i), .port3_o(port3_i));
  // Clock of 40 ns period.
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // A run that hangs is cut short here.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk_i);
  endtask
  task automatic wait_run;
    while (cpu_run_o !== 1'b1) @(posedge clk_i);
  endtask
  // Kick the watchdog if asked, then count RC ticks until it resets.
  task automatic wd(input int exp, input logic k);
    int n;
    n = 0;
    wdt_kick_i <= k;
    @(posedge clk_i);
    wdt_kick_i <= 1'b0;
    while (cpu_reset_o !== 1'b1) begin
      rc_tick_i <= 1'b1;
      @(posedge clk_i);
      rc_tick_i <= 1'b0;
      n++;
      repeat (2) @(posedge clk_i);
    end
    chk(n, exp);
  endtask
  task automatic stop;
    stop_req_i <= 1'b1;
    @(posedge clk_i);
    stop_req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic burst;
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_run();
    chk(cpu_reset_o, 0);
    wr(a_wdog, 8'hFD, SWC_RESP_OKAY);
    rd(a_wdog, 0, SWC_RESP_OKAY);
    rd(a_wake1, 0, SWC_RESP_OKAY);
    rd(12'h040, 0, SWC_RESP_SLVERR);
    wr(12'h040, 8'h01, SWC_RESP_SLVERR);
    halt_i <= 1'b1;
    wd(10, 1);
    halt_i <= 1'b0;
    wait_run();
    rd(a_wake1, 0, SWC_RESP_OKAY);
    wr(a_wdog, 8'h09, SWC_RESP_OKAY);
    halt_i <= 1'b1;
    wdt_kick_i <= 1'b1;
    @(posedge clk_i);
    wdt_kick_i <= 1'b0;
    repeat (15) begin
      rc_tick_i <= 1'b1;
      @(posedge clk_i);
      rc_tick_i <= 1'b0;
      @(posedge clk_i);
    end
    chk(cpu_reset_o, 0);
    halt_i <= 1'b0;
    repeat (70) @(posedge clk_i);
    wr(a_wdog, 8'h0E, SWC_RESP_OKAY);
    wd(10, 1);
    wait_run();
    wr(a_volt, 8'h01, SWC_RESP_OKAY);
    supply_low_i <= 1'b1;
    supply_high_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(a_volt, 32'h7, SWC_RESP_OKAY);
    supply_low_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(interrupt_request_five_o, 1);
    interrupt_request_five_clr_i <= 1'b1;
    @(posedge clk_i);
    interrupt_request_five_clr_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(interrupt_request_five_o, 0);
    wr(a_wake1, 8'h58, SWC_RESP_OKAY);
    wr(a_wake2, 8'h00, SWC_RESP_OKAY);
    stop();
    rd(a_volt, 32'h1, SWC_RESP_OKAY);
    burst();
    chk(cpu_run_o, 0);
    port2_out_i <= 8'h01;
    burst();
    chk(cpu_run_o, 1);
    rd(a_wake1, 32'h80, SWC_RESP_OKAY);
    wr(a_wake1, 8'h20, SWC_RESP_OKAY);
    wr(a_wake2, 8'h10, SWC_RESP_OKAY);
    stop();
    chk(cpu_reset_o, 1);
    wait_run();
    chk(restart_addr_o, 16'h000C);
    wdt_otp <= 1'b1;
    brownout_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(cpu_reset_o, 1);
    brownout_i <= 1'b0;
    wait_run();
    rd(a_wake1, 0, SWC_RESP_OKAY);
    wd(10, 0);
    print_verdict();
  end
endmodule
